// [sccu_top.sv]
// Sixteen-channel capture/compare unit with two reloadable time-base timers

//////////////////////////////////////////////////////////////////////////////
// Operation
// RQ1 - Sixteen channels, one or eight cycle resolution
// RQ2 - Two independent 16-bit timers with reload registers
// RQ3 - Timer clock: prescaled system clock or general overflow
// RQ4 - First timer may count external input events
// RQ5 - Channel selects timer and capture or compare
// RQ6 - Each channel owns one pin, input or output
// RQ7 - Mode 0: interrupt on every match only
// RQ8 - Mode 1: pin toggles on every match
// RQ9 - Mode 2: one interrupt per timer period
// RQ10 - Mode 3: set on match, clear on overflow
// RQ11 - Double register: two channels toggle one pin
// RQ12 - Single event option stops after one event
// RQ13 - Capture copies assigned timer into channel register
// RQ14 - Every capture raises the channel's request
// RQ15 - Capture edge: rising, falling or both
// RQ16 - Compare channels match continuously against their timer
// RQ17 - Timer reloads from reload register on overflow
// RQ18 - Outside triggers stable; synchronised before edge detection
module sccu_top #(
    parameter int unsigned NUM_CH = sccu_pkg::NUM_CH,
    parameter int unsigned TMR_W = sccu_pkg::TMR_W
) (
    input wire logic ref_clk_i, // System clock, 125 MHz
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic clk_en_i, // Freezes all state while low
    input wire logic [5:0] reg_addr_i, // Register word address
    input wire logic [15:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [15:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic [15:0] cc_pin_i, // Channel pin levels
    output logic [15:0] cc_pin_o, // Channel pin drive values
    output logic [15:0] cc_pin_oe_o, // Channel pin output enables
    output logic [15:0] cc_req_o, // Channel request pulses
    input wire logic gen_timer_ovf_i, // External general timer over/underflow pulse
    input wire logic ext_count_i // External count input for first timer
);

    initial begin
        if (NUM_CH != 16 || TMR_W != 16) begin
            $error("sccu_top serves exactly 16 channels of 16 bits");
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus request decode

    sccu_pkg::sccu_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    wire [1:0] req_page = req.addr[5:4];
    wire [3:0] req_idx = req.addr[3:0];
    wire wr_val_page = req.wr && (req_page == sccu_pkg::PAGE_VAL);
    wire wr_cfg_page = req.wr && (req_page == sccu_pkg::PAGE_CFG);
    wire wr_gctl = req.wr && (req.addr == sccu_pkg::ADDR_GCTL);

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [15:0] pin_s3_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;

    // Second stage only feeds logic; third stage holds the previous level
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
            pin_s3_q <= 16'h0000;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else if (clk_en_i) begin
            pin_s1_q <= cc_pin_i; // [RQ18]
            pin_s2_q <= pin_s1_q; // [RQ18]
            pin_s3_q <= pin_s2_q;
            ext_s1_q <= ext_count_i; // [RQ18]
            ext_s2_q <= ext_s1_q; // [RQ18]
            ext_s3_q <= ext_s2_q;
        end
    end

    wire [15:0] pin_rise = pin_s2_q & ~pin_s3_q;
    wire [15:0] pin_fall = ~pin_s2_q & pin_s3_q;
    wire ext_rise = ext_s2_q && !ext_s3_q; // [RQ4]

    //////////////////////////////////////////////////////////////////////////
    // Prescaler and global control

    logic [sccu_pkg::PRE_W-1:0] pre_q;
    logic stagger_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pre_q <= '0;
            stagger_q <= 1'b0;
        end else if (clk_en_i) begin
            pre_q <= pre_q + 1'b1;
            if (wr_gctl) begin
                stagger_q <= req.wdata[0];
            end
        end
    end

    // Staggered mode lets prescaled ticks through only every eighth cycle
    wire stagger_slot = !stagger_q || ((pre_q[2:0] & sccu_pkg::STAGGER_MASK) == 3'h0); // [RQ1]

    //////////////////////////////////////////////////////////////////////////
    // Time-base timers

    logic [15:0] tmr_q [2];
    logic [15:0] rld_q [2];
    sccu_pkg::sccu_tctl_s tctl_q [2];
    logic [1:0] upd_q;
    logic [1:0] ovf_q;

    for (genvar t = 0; t < 2; t++) begin : g_tmr
        wire [5:0] wr_base = (t == 0) ? sccu_pkg::ADDR_TMR1 : sccu_pkg::ADDR_TMR2;
        wire [5:0] rld_addr = (t == 0) ? sccu_pkg::ADDR_RLD1 : sccu_pkg::ADDR_RLD2;
        wire [5:0] ctl_addr = (t == 0) ? sccu_pkg::ADDR_TCTL1 : sccu_pkg::ADDR_TCTL2;
        wire [2:0] csel = tctl_q[t].csel;
        wire [7:0] div_mask = (8'h01 << csel) - 8'h01;
        wire pre_tick = (csel <= sccu_pkg::CSEL_MAX_DIV) && ((pre_q & div_mask) == 8'h00);
        // Only the first timer has an external count input
        wire ext_tick = (csel == sccu_pkg::CSEL_EXT_CNT) && (t == 0) && ext_rise; // [RQ4]
        wire gen_tick = (csel == sccu_pkg::CSEL_GEN_OVF) && gen_timer_ovf_i; // [RQ3]
        wire tick = tctl_q[t].run && ((pre_tick && stagger_slot) || gen_tick || ext_tick); // [RQ3]
        wire wrap = tick && (tmr_q[t] == sccu_pkg::TMR_MAX);

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                tmr_q[t] <= sccu_pkg::RST_WORD;
                rld_q[t] <= sccu_pkg::RST_WORD;
                tctl_q[t] <= '0;
                upd_q[t] <= 1'b0;
                ovf_q[t] <= 1'b0;
            end else if (clk_en_i) begin
                upd_q[t] <= tick;
                ovf_q[t] <= wrap;
                if (wrap) begin
                    tmr_q[t] <= rld_q[t]; // [RQ17]
                end else if (tick) begin
                    tmr_q[t] <= tmr_q[t] + 16'h0001; // [RQ2]
                end else if (req.wr && req.addr == wr_base) begin
                    tmr_q[t] <= req.wdata;
                end
                if (req.wr && req.addr == rld_addr) begin
                    rld_q[t] <= req.wdata; // [RQ2]
                end
                if (req.wr && req.addr == ctl_addr) begin
                    tctl_q[t] <= sccu_pkg::sccu_tctl_s'(req.wdata);
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Channels

    sccu_pkg::sccu_cfg_s cfg_q [16];
    logic [15:0] val_q [16];
    logic [15:0] pin_q;
    logic [15:0] oe_q;
    logic [15:0] spent_q;
    logic [15:0] once_q;
    logic [15:0] chreq_q;
    wire [15:0] match;

    for (genvar i = 0; i < 16; i++) begin : g_ch
        wire tsel = cfg_q[i].tsel; // [RQ5]
        wire [15:0] tv = tmr_q[tsel];
        wire upd = upd_q[tsel];
        wire ovf = ovf_q[tsel];
        wire is_cap = (cfg_q[i].func == sccu_pkg::FUNC_CAP) && !spent_q[i]; // [RQ5]
        wire is_cmp = (cfg_q[i].func == sccu_pkg::FUNC_CMP) && !spent_q[i]; // [RQ5]
        wire [1:0] cm = cfg_q[i].cmode;
        // Compare is evaluated each time the timer ticks; software writes to the timer are not compared
        assign match[i] = is_cmp && upd && (tv == val_q[i]); // [RQ16]
        wire cap_ev = is_cap && ((cfg_q[i].edge_sel[0] && pin_rise[i]) ||
            (cfg_q[i].edge_sel[1] && pin_fall[i])); // [RQ15]
        // Lower channel owns the shared pin; upper channel of the pair drives none
        wire pair_on = (i < 8) && cfg_q[i].dbl && (cm == sccu_pkg::CMP_TOGGLE); // [RQ11]
        wire pair_m = pair_on && match[(i + 8) % 16]; // [RQ11]
        wire shared_out = (i >= 8) && cfg_q[i % 8].dbl &&
            (cfg_q[i % 8].func == sccu_pkg::FUNC_CMP);
        wire ev_irq_all = match[i] && (cm == sccu_pkg::CMP_IRQ_ALL); // [RQ7]
        wire ev_toggle = (match[i] && (cm == sccu_pkg::CMP_TOGGLE)) || pair_m; // [RQ8]
        wire ev_once = match[i] && !once_q[i] && (cm == sccu_pkg::CMP_IRQ_ONCE); // [RQ9]
        wire ev_set = match[i] && !once_q[i] && (cm == sccu_pkg::CMP_SET_CLR); // [RQ10]
        wire ev_clr = is_cmp && ovf && (cm == sccu_pkg::CMP_SET_CLR); // [RQ10]
        wire any_ev = ev_irq_all || ev_toggle || ev_once || ev_set || cap_ev;
        wire drives = is_cmp && !shared_out &&
            ((cm == sccu_pkg::CMP_TOGGLE) || (cm == sccu_pkg::CMP_SET_CLR)); // [RQ6]
        wire wr_val = wr_val_page && (req_idx == 4'(i));
        wire wr_cfg = wr_cfg_page && (req_idx == 4'(i));

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                cfg_q[i] <= '0;
                val_q[i] <= sccu_pkg::RST_WORD;
                pin_q[i] <= 1'b0;
                oe_q[i] <= 1'b0;
                spent_q[i] <= 1'b0;
                once_q[i] <= 1'b0;
                chreq_q[i] <= 1'b0;
            end else if (clk_en_i) begin
                // A capture beats a software write in the same cycle
                if (cap_ev) begin
                    val_q[i] <= tv; // [RQ13]
                end else if (wr_val) begin
                    val_q[i] <= req.wdata;
                end
                if (wr_cfg) begin
                    cfg_q[i] <= sccu_pkg::sccu_cfg_s'(req.wdata);
                end
                chreq_q[i] <= cap_ev || ev_irq_all || ev_once; // [RQ14] [RQ7] [RQ9]
                oe_q[i] <= drives; // [RQ6]
                if (ev_set) begin
                    pin_q[i] <= 1'b1; // [RQ10]
                end else if (ev_clr) begin
                    pin_q[i] <= 1'b0; // [RQ10]
                end else if (ev_toggle) begin
                    pin_q[i] <= !pin_q[i]; // [RQ8] [RQ11]
                end
                // Period lock: a new match in the overflow cycle still locks
                if (ev_once || ev_set) begin
                    once_q[i] <= 1'b1; // [RQ9] [RQ10]
                end else if (ovf || wr_cfg) begin
                    once_q[i] <= 1'b0;
                end
                // Rewriting the configuration rearms a spent single-event channel
                if (wr_cfg) begin
                    spent_q[i] <= 1'b0;
                end else if (cfg_q[i].single && any_ev) begin
                    spent_q[i] <= 1'b1; // [RQ12]
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path

    wire [15:0] rd_misc =
        (req.addr == sccu_pkg::ADDR_TMR1) ? tmr_q[0] :
        (req.addr == sccu_pkg::ADDR_TMR2) ? tmr_q[1] :
        (req.addr == sccu_pkg::ADDR_RLD1) ? rld_q[0] :
        (req.addr == sccu_pkg::ADDR_RLD2) ? rld_q[1] :
        (req.addr == sccu_pkg::ADDR_TCTL1) ? 16'(tctl_q[0]) :
        (req.addr == sccu_pkg::ADDR_TCTL2) ? 16'(tctl_q[1]) :
        (req.addr == sccu_pkg::ADDR_GCTL) ? {15'h0000, stagger_q} :
        (req.addr == sccu_pkg::ADDR_PINS) ? pin_q :
        (req.addr == sccu_pkg::ADDR_SPENT) ? spent_q : 16'h0000;
    wire [15:0] rd_word =
        (req_page == sccu_pkg::PAGE_VAL) ? val_q[req_idx] :
        (req_page == sccu_pkg::PAGE_CFG) ? 16'(cfg_q[req_idx]) :
        (req_page == 2'h0) ? rd_misc : 16'h0000;

    logic [15:0] rdata_q;
    logic [15:0] pin_out_q;
    logic [15:0] oe_out_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 16'h0000;
        end else if (clk_en_i) begin
            rdata_q <= req.rd ? rd_word : 16'h0000;
        end
    end

    // Pin outputs come straight from the channel flops
    always_comb begin
        pin_out_q = pin_q;
        oe_out_q = oe_q;
    end

    assign reg_rdata_o = rdata_q;
    assign cc_pin_o = pin_out_q;
    assign cc_pin_oe_o = oe_out_q;
    assign cc_req_o = chreq_q;

endmodule

// [sccu_pkg.sv]
// Package with the register map, field layouts and source codes of the capture/compare unit
package sccu_pkg;

    localparam int unsigned NUM_CH = 16;
    localparam int unsigned TMR_W = 16;
    localparam int unsigned ADDR_W = 6;

    // Register word addresses
    localparam logic [5:0] ADDR_TMR1 = 6'h00;
    localparam logic [5:0] ADDR_TMR2 = 6'h01;
    localparam logic [5:0] ADDR_RLD1 = 6'h02;
    localparam logic [5:0] ADDR_RLD2 = 6'h03;
    localparam logic [5:0] ADDR_TCTL1 = 6'h04;
    localparam logic [5:0] ADDR_TCTL2 = 6'h05;
    localparam logic [5:0] ADDR_GCTL = 6'h06;
    localparam logic [5:0] ADDR_PINS = 6'h07;
    localparam logic [5:0] ADDR_SPENT = 6'h08;
    localparam logic [1:0] PAGE_VAL = 2'h1;
    localparam logic [1:0] PAGE_CFG = 2'h2;

    // Channel function field
    localparam logic [1:0] FUNC_OFF = 2'h0;
    localparam logic [1:0] FUNC_CAP = 2'h1;
    localparam logic [1:0] FUNC_CMP = 2'h2;

    // Compare modes
    localparam logic [1:0] CMP_IRQ_ALL = 2'h0;
    localparam logic [1:0] CMP_TOGGLE = 2'h1;
    localparam logic [1:0] CMP_IRQ_ONCE = 2'h2;
    localparam logic [1:0] CMP_SET_CLR = 2'h3;

    // Timer clock sources: 0 every cycle, 1..5 divide by 2**sel
    localparam logic [2:0] CSEL_MAX_DIV = 3'h5;
    localparam logic [2:0] CSEL_GEN_OVF = 3'h6;
    localparam logic [2:0] CSEL_EXT_CNT = 3'h7;

    localparam int unsigned PRE_W = 8;
    localparam logic [2:0] STAGGER_MASK = 3'h7;
    localparam logic [15:0] TMR_MAX = 16'hffff;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef struct packed {
        logic [6:0] rsvd;
        logic dbl;
        logic single;
        logic tsel;
        logic [1:0] cmode;
        logic [1:0] edge_sel;
        logic [1:0] func;
    } sccu_cfg_s;

    typedef struct packed {
        logic [11:0] rsvd;
        logic [2:0] csel;
        logic run;
    } sccu_tctl_s;

    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sccu_req_s;

endpackage

// [sccu_assertions.sv]
// Port-level checks of the capture/compare unit, bound to its top
module sccu_assertions #(
    parameter int unsigned NUM_CH = 16,
    parameter int unsigned TMR_W = 16
) (
    input wire logic ref_clk_i, // System clock
    input wire logic sys_rst_i, // Reset
    input wire logic clk_en_i, // Clock enable
    input wire logic [5:0] reg_addr_i, // Address
    input wire logic [15:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [15:0] reg_rdata_o, // Read data
    input wire logic [15:0] cc_pin_i, // Pin levels
    input wire logic [15:0] cc_pin_o, // Pin drive values
    input wire logic [15:0] cc_pin_oe_o, // Pin enables
    input wire logic [15:0] cc_req_o, // Requests
    input wire logic gen_timer_ovf_i, // General timer pulse
    input wire logic ext_count_i // External count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [15:0] cfg_q [16];
    logic [15:0] exp_q;
    logic [15:0] drive_ok, active, quiet;
    wire logic cfg_hit = clk_en_i && reg_addr_i[5:4] == sccu_pkg::PAGE_CFG;
    // Shadow of the channel setup, so outputs can be judged per channel
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            drive_ok[n] = cfg_q[n][1:0] == sccu_pkg::FUNC_CMP && cfg_q[n][4];
            active[n] = cfg_q[n][1:0] != sccu_pkg::FUNC_OFF;
            quiet[n] = drive_ok[n] && !cfg_q[n][5];
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= '{default: 16'h0000};
            exp_q <= 16'h0000;
        end else begin
            if (cfg_hit && reg_wr_i) cfg_q[reg_addr_i[3:0]] <= reg_wdata_i;
            if (cfg_hit && reg_rd_i) exp_q <= cfg_q[reg_addr_i[3:0]];
        end
    end
    a_read_idle_zero: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (clk_en_i && reg_rd_i &&
        (reg_addr_i inside {[6'h09:6'h0f], [6'h30:6'h3f]}) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read returned data");
    a_cfg_read_back: assert property (reg_rd_i && cfg_hit |=> reg_rdata_o[8:0] == exp_q[8:0])
        else $error("channel setup read back wrong");
    a_freeze_pins: assert property (!clk_en_i |=> $stable(cc_pin_o) && $stable(cc_pin_oe_o))
        else $error("pins moved while frozen");
    a_freeze_req: assert property (!clk_en_i |=> $stable(cc_req_o) && $stable(reg_rdata_o))
        else $error("requests moved while frozen");
    a_drive_modes_only: assert property ((cc_pin_oe_o &
        ~(drive_ok | $past(drive_ok) | $past(drive_ok, 2))) == 16'h0000)
        else $error("pin driven outside toggle or set-clear mode");
    a_req_active_only: assert property ((cc_req_o &
        ~(active | $past(active) | $past(active, 2))) == 16'h0000)
        else $error("request from a disabled channel");
    a_toggle_no_req: assert property ((cc_req_o & quiet & $past(quiet) & $past(quiet, 2)) == 16'h0000)
        else $error("request from a toggle channel");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sccu_top sccu_assertions #(.NUM_CH(NUM_CH), .TMR_W(TMR_W)) u_sccu_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cc_pin_i(cc_pin_i),
    .cc_pin_o(cc_pin_o), .cc_pin_oe_o(cc_pin_oe_o), .cc_req_o(cc_req_o),
    .gen_timer_ovf_i(gen_timer_ovf_i), .ext_count_i(ext_count_i)
);

// [sccu_far_side.sv]
// Far side of the channel pins: outside event sources and the pin loads
module sccu_far_side (
    input wire logic [15:0] pin_o_i, // Drive values from the unit
    input wire logic [15:0] pin_oe_i, // Enables from the unit
    input wire logic [15:0] src_lvl_i, // Outside source levels
    output logic [15:0] pin_lvl_o // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the unit's value, an undriven one its source
    assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & src_lvl_i);
endmodule

// [tb_sccu_top.sv]
// Self-checking testbench of the capture/compare unit
module tb_sccu_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CFG_TAB [8] = '{16'h0012, 16'h0032, 16'h0022, 16'h0002,
        16'h0045, 16'h0049, 16'h004d, 16'h0092};
    localparam logic [15:0] VAL_TAB [8] = '{16'hfff0, 16'hfff0, 16'hfff8, 16'hfff8,
        16'h0000, 16'h0000, 16'h0000, 16'hffe8};
    logic ref_clk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i, gen_timer_ovf_i, ext_count_i;
    logic [5:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, cc_pin_i, cc_pin_o, cc_pin_oe_o, cc_req_o, src_lvl;
    logic [15:0] prev_pin = 16'h0000;
    int req_cnt [16] = '{default: 0};
    int tog_cnt [16] = '{default: 0};
    int hi_cnt = 0;
    int err_count = 0;
    int compares = 0;
    sccu_top uut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cc_pin_i(cc_pin_i),
        .cc_pin_o(cc_pin_o), .cc_pin_oe_o(cc_pin_oe_o), .cc_req_o(cc_req_o),
        .gen_timer_ovf_i(gen_timer_ovf_i), .ext_count_i(ext_count_i)
    );
    sccu_far_side u_far (.pin_o_i(cc_pin_o), .pin_oe_i(cc_pin_oe_o), .src_lvl_i(src_lvl),
        .pin_lvl_o(cc_pin_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // Event counters; a whole number of timer periods gives exact totals
    always @(posedge ref_clk_i) begin
        for (int n = 0; n < 16; n++) begin
            req_cnt[n] += int'(cc_req_o[n] === 1'b1);
            tog_cnt[n] += int'(cc_pin_o[n] !== prev_pin[n]);
        end
        hi_cnt += int'(cc_pin_o[1] === 1'b1);
        prev_pin = cc_pin_o;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic win(input int n);
        @(negedge ref_clk_i);
        req_cnt = '{default: 0};
        tog_cnt = '{default: 0};
        hi_cnt = 0;
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic t_regs;
        wr(sccu_pkg::ADDR_RLD1, 16'hffe0);
        rdc(sccu_pkg::ADDR_RLD1, 16'hffe0);
        wr(sccu_pkg::ADDR_TMR2, 16'h0abc);
        rdc(sccu_pkg::ADDR_TMR2, 16'h0abc);
        wr(6'h30, 16'hffff);
        rdc(6'h30, 16'h0000);
        rdc(6'h09, 16'h0000);
    endtask
    task automatic t_compare;
        wr(sccu_pkg::ADDR_TMR1, 16'hffe0);
        for (int n = 0; n < 8; n++) begin
            wr(6'h20 + 6'(n), CFG_TAB[n]);
            wr(6'h10 + 6'(n), VAL_TAB[n]);
            rdc(6'h20 + 6'(n), CFG_TAB[n]);
        end
        wr(sccu_pkg::ADDR_TCTL1, 16'h0001);
        repeat (40) @(posedge ref_clk_i);
        win(64);
        chk(16'(tog_cnt[0]), 16'h0002);
        chk(16'(req_cnt[0]), 16'h0000);
        chk(16'(tog_cnt[1]), 16'h0004);
        chk(16'(hi_cnt), 16'h0020);
        chk(16'(req_cnt[2]), 16'h0002);
        chk(16'(req_cnt[3]), 16'h0002);
        chk(16'(tog_cnt[7]), 16'h0000);
        chk(cc_pin_oe_o, 16'h0003);
        rdc(sccu_pkg::ADDR_SPENT, 16'h0080);
    endtask
    task automatic t_lock;
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
        wr(sccu_pkg::ADDR_TMR1, 16'hfff0);
        win(0);
        wr(6'h22, 16'h0022);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0001);
        repeat (12) @(posedge ref_clk_i);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
        wr(sccu_pkg::ADDR_TMR1, 16'hfff4);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0001);
        repeat (8) @(posedge ref_clk_i);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
        repeat (4) @(negedge ref_clk_i);
        chk(16'(req_cnt[3]), 16'h0002);
        chk(16'(req_cnt[2]), 16'h0001);
    endtask
    task automatic t_freeze;
        wr(sccu_pkg::ADDR_TCTL1, 16'h0001);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b0;
        @(posedge ref_clk_i);
        win(40);
        chk(16'(tog_cnt[0] + tog_cnt[1]), 16'h0000);
        @(posedge ref_clk_i);
        clk_en_i <= 1'b1;
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
    endtask
    task automatic t_capture;
        win(4);
        @(posedge ref_clk_i);
        src_lvl <= 16'h0070;
        repeat (8) @(posedge ref_clk_i);
        src_lvl <= 16'h0000;
        repeat (8) @(negedge ref_clk_i);
        chk(16'(req_cnt[4]), 16'h0001);
        chk(16'(req_cnt[5]), 16'h0001);
        chk(16'(req_cnt[6]), 16'h0002);
        rdc(6'h14, 16'h0abc);
    endtask
    task automatic t_sources;
        wr(sccu_pkg::ADDR_TCTL2, 16'h000d);
        repeat (5) begin
            @(posedge ref_clk_i);
            gen_timer_ovf_i <= 1'b1;
            @(posedge ref_clk_i);
            gen_timer_ovf_i <= 1'b0;
        end
        rdc(sccu_pkg::ADDR_TMR2, 16'h0ac1);
        wr(sccu_pkg::ADDR_TMR1, 16'h0100);
        wr(sccu_pkg::ADDR_TCTL1, 16'h000f);
        repeat (3) begin
            @(posedge ref_clk_i);
            ext_count_i <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            ext_count_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
        rdc(sccu_pkg::ADDR_TMR1, 16'h0103);
    endtask
    // Double register pair 0/8, then prescaled and staggered tick rates
    task automatic t_modes;
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
        wr(sccu_pkg::ADDR_TMR1, 16'hffe0);
        wr(6'h20, 16'h0112);
        wr(6'h28, 16'h0002);
        wr(6'h18, 16'hfff8);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0005);
        repeat (20) @(posedge ref_clk_i);
        win(256);
        chk(16'(tog_cnt[0]), 16'h0004);
        chk(16'(req_cnt[8]), 16'h0002);
        chk(cc_pin_oe_o & 16'h0101, 16'h0001);
        wr(sccu_pkg::ADDR_GCTL, 16'h0001);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0001);
        repeat (20) @(posedge ref_clk_i);
        win(512);
        chk(16'(tog_cnt[0]), 16'h0004);
        wr(sccu_pkg::ADDR_GCTL, 16'h0000);
        wr(sccu_pkg::ADDR_TCTL1, 16'h0000);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        clk_en_i = 1'b1;
        {reg_wr_i, reg_rd_i, gen_timer_ovf_i, ext_count_i} = 4'h0;
        reg_addr_i = 6'h00;
        reg_wdata_i = 16'h0000;
        src_lvl = 16'h0000;
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_compare();
        t_lock();
        t_freeze();
        t_capture();
        t_sources();
        t_modes();
        wrap_up();
    end
endmodule
